/* hdl/rcs_pkg.sv */
// Shared constants, encodings and reset values of the run command and step select block
package rcs_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int AW  = 8;   // Register address width
  localparam int DW  = 32;  // Register data width
  localparam int FQW = 16;  // Frequency word, 0.01 Hz units
  localparam int FNW = 5;   // Terminal function code width
  localparam int NIN = 8;   // Programmable input terminals

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [AW-1:0] OFS_CTRL    = 8'h00;
  localparam logic [AW-1:0] OFS_FUNC_LO = 8'h04;
  localparam logic [AW-1:0] OFS_FUNC_HI = 8'h08;
  localparam logic [AW-1:0] OFS_SERIAL  = 8'h0C;
  localparam logic [AW-1:0] OFS_PRESET1 = 8'h10;
  localparam logic [AW-1:0] OFS_PRESET7 = 8'h28;
  localparam logic [AW-1:0] OFS_STATUS  = 8'h2C;
  localparam logic [AW-1:0] OFS_TARGET  = 8'h30;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_FSRC_LSB = 0;
  localparam int CTRL_RSRC_LSB = 4;
  localparam int CTRL_KDIR_BIT = 6;
  localparam int CTRL_INH_LSB  = 8;
  localparam int CTRL_PUA_BIT  = 10;
  localparam int CTRL_FCA_BIT  = 11;
  localparam int FUNC_STRIDE   = 8;
  localparam int SER_PROT_BIT  = 0;
  localparam int SER_STN_LSB   = 8;
  localparam int SER_RATE_LSB  = 16;
  localparam int STAT_DIR_BIT  = 2;
  localparam int STAT_STEP_LSB = 3;
  localparam int STAT_HOLD_BIT = 6;
  localparam int STAT_ARM_BIT  = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // Terminal function codes and setting values
  localparam logic [FNW-1:0] FUNC_FWD     = 5'h00;
  localparam logic [FNW-1:0] FUNC_REV     = 5'h01;
  localparam logic [FNW-1:0] FUNC_STEP_LO = 5'h05;
  localparam logic [FNW-1:0] FUNC_STEP_MI = 5'h06;
  localparam logic [FNW-1:0] FUNC_STEP_HI = 5'h07;
  localparam logic [FNW-1:0] FUNC_HOLD    = 5'h17;
  localparam logic [3:0]     FSRC_BIPOLAR  = 4'h2;
  localparam logic [3:0]     FSRC_HOLD_MIN = 4'h2;
  localparam logic [3:0]     FSRC_HOLD_MAX = 4'h7;
  localparam logic [1:0]     INH_FWD       = 2'h1;
  localparam logic [1:0]     INH_REV       = 2'h2;
  localparam logic [7:0]     STATION_MIN   = 8'h01;
  localparam logic [7:0]     STATION_MAX   = 8'hFA;

  typedef enum logic [1:0] {
    RSRC_KEYPAD  = 2'h0,
    RSRC_TERM_FR = 2'h1,
    RSRC_TERM_RD = 2'h2,
    RSRC_SERIAL  = 2'h3
  } rcs_rsrc_t;

  // Gray along stop, run, reverse-decel; halt-decel closes the ring
  typedef enum logic [1:0] {
    ST_STOP    = 2'b00,
    ST_RUN     = 2'b01,
    ST_REVERSE = 2'b11,
    ST_HALT    = 2'b10
  } rcs_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and timing
  localparam logic [3:0]       RST_FSRC    = 4'h0;
  localparam rcs_rsrc_t        RST_RSRC    = RSRC_TERM_FR;
  localparam logic [7:0][4:0]  RST_FUNC    = {5'h07, 5'h06, 5'h05, 5'h04,
                                              5'h03, 5'h02, 5'h01, 5'h00};
  localparam logic [6:0][15:0] RST_PRESET  = {16'h05DC, 16'h07D0, 16'h09C4, 16'h0BB8,
                                              16'h0BB8, 16'h07D0, 16'h03E8};
  localparam logic [7:0]       RST_STATION = 8'h01;
  localparam logic [2:0]       RST_RATE    = 3'h3;
  localparam logic [1:0]       POR_SETTLE  = 2'h3;  // Synchroniser depth plus one
endpackage

/* hdl/rcs_sync2.sv */
// Two-stage level synchroniser for pin inputs
module rcs_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rcs_sync_t;

  rcs_sync_t s_r;
  rcs_sync_t s_nxt;

  // First stage feeds only the second
  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.s2;
endmodule

/* hdl/rcs_func_hit.sv */
// Flags when any terminal assigned a given function code is on
module rcs_func_hit #(
  parameter logic [4:0] CODE = 5'h00,
  parameter int         N    = 8
) (
  // Terminal function assignments, five bits each
  input  wire logic [N*5-1:0] func,
  // Synchronised terminal levels
  input  wire logic [N-1:0]   lvl,
  output logic                hit
);

  // Several terminals may share a code; any one of them asserts the function
  always_comb begin
    hit = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (lvl[i] && (func[i*5 +: 5] == CODE)) begin
        hit = 1'b1;
      end
    end
  end
endmodule

/* hdl/rcs_run_select.sv */
// Run command, direction and preset step selection for the motor drive
module rcs_run_select (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Pins, asynchronous
  input  wire logic [7:0]  prog_in,
  input  wire logic        key_run_body,
  input  wire logic        key_stop_body,
  input  wire logic        key_run_remote,
  input  wire logic        key_stop_remote,
  input  wire logic        remote_present,
  input  wire logic        bipolar_negative,
  // Drive internals, same clock
  input  wire logic        fault_active,
  input  wire logic        ramp_at_zero,
  input  wire logic [15:0] src_freq,
  input  wire logic        ser_cmd_valid,
  input  wire logic [7:0]  ser_cmd_station,
  input  wire logic        ser_cmd_run,
  input  wire logic        ser_cmd_reverse,
  // Run outputs
  output logic             run_enable,
  output logic             decel_stop,
  output logic             dir_reverse,
  output logic      [15:0] target_freq,
  output logic      [2:0]  step_index,
  output logic             analog_hold,
  // Serial link settings
  output logic             serial_protocol,
  output logic      [7:0]  station_number,
  output logic      [2:0]  serial_rate_code
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [3:0]               fsrc;
    rcs_pkg::rcs_rsrc_t       rsrc;
    logic                     kdir;
    logic [1:0]               inh;
    logic                     pua;
    logic                     fca;
    logic [7:0][4:0]          func;
    logic [6:0][15:0]         preset;
    logic                     prot;
    logic [7:0]               station;
    logic [2:0]               rate;
    logic [31:0]              rdata;
    logic [1:0]               key_prev;
    logic                     kp_run;
    logic                     ser_run;
    logic                     ser_rev;
    logic                     armed;
    logic                     fault_prev;
    logic [1:0]               por_cnt;
    rcs_pkg::rcs_state_t      state;
    logic                     dir;
    logic [2:0]               step;
    logic                     hold;
    logic [15:0]              target;
    logic                     run_en;
    logic                     decel;
  } rcs_regs_t;

  rcs_regs_t   s_r;
  rcs_regs_t   s_nxt;
  logic [13:0] sy;
  logic        fx;
  logic        rx;
  logic [2:0]  step_bits;
  logic        hold_hit;
  logic        key_run;
  logic        key_stop;
  logic        por_done;
  logic        term_src;
  logic        term_req;
  logic        fault_fall;
  logic        stn_ok;
  logic        req;
  logic        rdir;
  logic        blocked;
  logic        want;

  ////////////////////////////////////////////////////////////////////////////////
  // Input conditioning

  // Every pin passes two flops before any decode sees it
  rcs_sync2 #(.W(14)) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .d       ({bipolar_negative, remote_present, key_stop_remote, key_run_remote,
                key_stop_body, key_run_body, prog_in}),
    .q       (sy)
  );

  // Function decode over all terminals, so any terminal may carry any role
  rcs_func_hit #(.CODE(rcs_pkg::FUNC_FWD)) u_fx (
    .func (s_r.func),
    .lvl  (sy[7:0]),
    .hit  (fx)
  );
  rcs_func_hit #(.CODE(rcs_pkg::FUNC_REV)) u_rx (
    .func (s_r.func),
    .lvl  (sy[7:0]),
    .hit  (rx)
  );
  rcs_func_hit #(.CODE(rcs_pkg::FUNC_STEP_LO)) u_st0 (
    .func (s_r.func),
    .lvl  (sy[7:0]),
    .hit  (step_bits[0])
  );
  rcs_func_hit #(.CODE(rcs_pkg::FUNC_STEP_MI)) u_st1 (
    .func (s_r.func),
    .lvl  (sy[7:0]),
    .hit  (step_bits[1])
  );
  rcs_func_hit #(.CODE(rcs_pkg::FUNC_STEP_HI)) u_st2 (
    .func (s_r.func),
    .lvl  (sy[7:0]),
    .hit  (step_bits[2])
  );
  rcs_func_hit #(.CODE(rcs_pkg::FUNC_HOLD)) u_hold (
    .func (s_r.func),
    .lvl  (sy[7:0]),
    .hit  (hold_hit)
  );

  // Built-in keys go dead while a remote keypad is present
  assign key_run  = sy[12] ? sy[10] : sy[8];
  assign key_stop = sy[12] ? sy[11] : sy[9];

  // Misc qualifiers
  assign por_done   = (s_r.por_cnt == rcs_pkg::POR_SETTLE);
  assign term_src   = (s_r.rsrc == rcs_pkg::RSRC_TERM_FR) || (s_r.rsrc == rcs_pkg::RSRC_TERM_RD);
  assign term_req   = (s_r.rsrc == rcs_pkg::RSRC_TERM_FR) ? (fx ^ rx) : fx;
  assign fault_fall = s_r.fault_prev && !fault_active;
  assign stn_ok     = (s_r.station >= rcs_pkg::STATION_MIN) &&
                      (s_r.station <= rcs_pkg::STATION_MAX) &&
                      (ser_cmd_station == s_r.station);

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    s_nxt = s_r;

    // Run request per command source
    case (s_r.rsrc)
      rcs_pkg::RSRC_KEYPAD: begin
        req  = s_r.kp_run;
        rdir = s_r.kdir;
      end
      rcs_pkg::RSRC_TERM_FR: begin
        req  = fx ^ rx;
        rdir = rx;
      end
      rcs_pkg::RSRC_TERM_RD: begin
        req  = fx;
        rdir = rx;
      end
      default: begin
        req  = s_r.ser_run;
        rdir = s_r.ser_rev;
      end
    endcase
    // Negative bipolar reference flips the commanded direction
    if (s_r.fsrc == rcs_pkg::FSRC_BIPOLAR) begin
      rdir = rdir ^ sy[13];
    end
    blocked = ((s_r.inh == rcs_pkg::INH_FWD) && !rdir) ||
              ((s_r.inh == rcs_pkg::INH_REV) && rdir);
    want    = req && s_r.armed && por_done && !fault_active && !blocked;

    // Power-on settle: wait for the synchronisers before judging levels
    if (!por_done) begin
      s_nxt.por_cnt = s_r.por_cnt + 2'h1;
    end
    s_nxt.fault_prev = fault_active;

    // A terminal run already on must see an off first, unless autostart says not
    if (fault_active) begin
      s_nxt.armed = 1'b0;
    end else if (fault_fall) begin
      s_nxt.armed = (s_r.fca && term_src) || !term_src || !term_req;
    end else if (s_r.por_cnt == rcs_pkg::POR_SETTLE - 2'h1) begin
      s_nxt.armed = (s_r.pua && term_src) || !term_src || !term_req;
    end else if (por_done && (!term_src || !term_req)) begin
      s_nxt.armed = 1'b1;
    end

    // Keypad latch; stop beats run when both edges land together
    s_nxt.key_prev = {key_stop, key_run};
    if (fault_active || (s_r.rsrc != rcs_pkg::RSRC_KEYPAD)) begin
      s_nxt.kp_run = 1'b0;
    end else if (key_stop && !s_r.key_prev[1]) begin
      s_nxt.kp_run = 1'b0;
    end else if (key_run && !s_r.key_prev[0]) begin
      s_nxt.kp_run = 1'b1;
    end

    // Serial latch, only for our own station and only under serial control
    if (fault_active || (s_r.rsrc != rcs_pkg::RSRC_SERIAL)) begin
      s_nxt.ser_run = 1'b0;
    end else if (ser_cmd_valid && stn_ok) begin
      s_nxt.ser_run = ser_cmd_run;
      s_nxt.ser_rev = ser_cmd_reverse;
    end

    // Run sequencer; a reversal always passes through zero speed
    case (s_r.state)
      rcs_pkg::ST_STOP: begin
        if (want) begin
          s_nxt.state = rcs_pkg::ST_RUN;
          s_nxt.dir   = rdir;
        end
      end
      rcs_pkg::ST_RUN: begin
        if (!want) begin
          s_nxt.state = rcs_pkg::ST_HALT;
        end else if (rdir != s_r.dir) begin
          s_nxt.state = rcs_pkg::ST_REVERSE;
        end
      end
      rcs_pkg::ST_REVERSE: begin
        if (!want) begin
          s_nxt.state = rcs_pkg::ST_HALT;
        end else if (ramp_at_zero) begin
          s_nxt.state = rcs_pkg::ST_RUN;
          s_nxt.dir   = rdir;
        end
      end
      default: begin
        if (ramp_at_zero) begin
          s_nxt.state = rcs_pkg::ST_STOP;
        end
      end
    endcase
    s_nxt.run_en = (s_nxt.state == rcs_pkg::ST_RUN);
    s_nxt.decel  = (s_nxt.state == rcs_pkg::ST_REVERSE) || (s_nxt.state == rcs_pkg::ST_HALT);

    // Step select counts only while a run is requested
    s_nxt.step = want ? step_bits : 3'h0;
    s_nxt.hold = hold_hit && (s_r.fsrc >= rcs_pkg::FSRC_HOLD_MIN) &&
                 (s_r.fsrc <= rcs_pkg::FSRC_HOLD_MAX);
    if (s_nxt.step != 3'h0) begin
      s_nxt.target = s_r.preset[3'(s_nxt.step - 3'h1)];
    end else if (!s_nxt.hold) begin
      s_nxt.target = src_freq;
    end

    // Register writes
    if (reg_wr) begin
      if (reg_addr == rcs_pkg::OFS_CTRL) begin
        s_nxt.fsrc = reg_wdata[rcs_pkg::CTRL_FSRC_LSB +: 4];
        s_nxt.rsrc = rcs_pkg::rcs_rsrc_t'(reg_wdata[rcs_pkg::CTRL_RSRC_LSB +: 2]);
        s_nxt.kdir = reg_wdata[rcs_pkg::CTRL_KDIR_BIT];
        s_nxt.inh  = reg_wdata[rcs_pkg::CTRL_INH_LSB +: 2];
        s_nxt.pua  = reg_wdata[rcs_pkg::CTRL_PUA_BIT];
        s_nxt.fca  = reg_wdata[rcs_pkg::CTRL_FCA_BIT];
      end else if (reg_addr == rcs_pkg::OFS_FUNC_LO) begin
        for (int i = 0; i < 4; i++) begin
          s_nxt.func[i] = reg_wdata[i*rcs_pkg::FUNC_STRIDE +: 5];
        end
      end else if (reg_addr == rcs_pkg::OFS_FUNC_HI) begin
        for (int i = 0; i < 4; i++) begin
          s_nxt.func[i+4] = reg_wdata[i*rcs_pkg::FUNC_STRIDE +: 5];
        end
      end else if (reg_addr == rcs_pkg::OFS_SERIAL) begin
        s_nxt.prot    = reg_wdata[rcs_pkg::SER_PROT_BIT];
        s_nxt.station = reg_wdata[rcs_pkg::SER_STN_LSB +: 8];
        s_nxt.rate    = reg_wdata[rcs_pkg::SER_RATE_LSB +: 3];
      end else if ((reg_addr >= rcs_pkg::OFS_PRESET1) && (reg_addr <= rcs_pkg::OFS_PRESET7) &&
                   (reg_addr[1:0] == 2'h0)) begin
        s_nxt.preset[3'((reg_addr - rcs_pkg::OFS_PRESET1) >> 2)] = reg_wdata[15:0];
      end
    end

    // Register reads; data stand for one cycle, unmapped reads give zero
    s_nxt.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == rcs_pkg::OFS_CTRL) begin
        s_nxt.rdata[rcs_pkg::CTRL_FSRC_LSB +: 4] = s_r.fsrc;
        s_nxt.rdata[rcs_pkg::CTRL_RSRC_LSB +: 2] = s_r.rsrc;
        s_nxt.rdata[rcs_pkg::CTRL_KDIR_BIT]      = s_r.kdir;
        s_nxt.rdata[rcs_pkg::CTRL_INH_LSB +: 2]  = s_r.inh;
        s_nxt.rdata[rcs_pkg::CTRL_PUA_BIT]       = s_r.pua;
        s_nxt.rdata[rcs_pkg::CTRL_FCA_BIT]       = s_r.fca;
      end else if (reg_addr == rcs_pkg::OFS_FUNC_LO) begin
        for (int i = 0; i < 4; i++) begin
          s_nxt.rdata[i*rcs_pkg::FUNC_STRIDE +: 5] = s_r.func[i];
        end
      end else if (reg_addr == rcs_pkg::OFS_FUNC_HI) begin
        for (int i = 0; i < 4; i++) begin
          s_nxt.rdata[i*rcs_pkg::FUNC_STRIDE +: 5] = s_r.func[i+4];
        end
      end else if (reg_addr == rcs_pkg::OFS_SERIAL) begin
        s_nxt.rdata[rcs_pkg::SER_PROT_BIT]       = s_r.prot;
        s_nxt.rdata[rcs_pkg::SER_STN_LSB +: 8]   = s_r.station;
        s_nxt.rdata[rcs_pkg::SER_RATE_LSB +: 3]  = s_r.rate;
      end else if ((reg_addr >= rcs_pkg::OFS_PRESET1) && (reg_addr <= rcs_pkg::OFS_PRESET7) &&
                   (reg_addr[1:0] == 2'h0)) begin
        s_nxt.rdata[15:0] = s_r.preset[3'((reg_addr - rcs_pkg::OFS_PRESET1) >> 2)];
      end else if (reg_addr == rcs_pkg::OFS_STATUS) begin
        s_nxt.rdata[1:0]                         = s_r.state;
        s_nxt.rdata[rcs_pkg::STAT_DIR_BIT]       = s_r.dir;
        s_nxt.rdata[rcs_pkg::STAT_STEP_LSB +: 3] = s_r.step;
        s_nxt.rdata[rcs_pkg::STAT_HOLD_BIT]      = s_r.hold;
        s_nxt.rdata[rcs_pkg::STAT_ARM_BIT]       = s_r.armed;
      end else if (reg_addr == rcs_pkg::OFS_TARGET) begin
        s_nxt.rdata[15:0] = s_r.target;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  // Configuration comes up at its documented defaults, the motor stopped
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_r         <= '0;
      s_r.fsrc    <= rcs_pkg::RST_FSRC;
      s_r.rsrc    <= rcs_pkg::RST_RSRC;
      s_r.func    <= rcs_pkg::RST_FUNC;
      s_r.preset  <= rcs_pkg::RST_PRESET;
      s_r.station <= rcs_pkg::RST_STATION;
      s_r.rate    <= rcs_pkg::RST_RATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata        = s_r.rdata;
  assign run_enable       = s_r.run_en;
  assign decel_stop       = s_r.decel;
  assign dir_reverse      = s_r.dir;
  assign target_freq      = s_r.target;
  assign step_index       = s_r.step;
  assign analog_hold      = s_r.hold;
  assign serial_protocol  = s_r.prot;
  assign station_number   = s_r.station;
  assign serial_rate_code = s_r.rate;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_hold_range: assert property (analog_hold |-> $past(s_r.fsrc) >= 4'h2 &&
                                   $past(s_r.fsrc) <= 4'h7)
    else $error("analog hold outside sources two to seven");
  chk_step_idle: assert property (!$past(want) |-> step_index == 3'h0)
    else $error("step index nonzero without a run request");
  chk_step_zero: assert property (step_index == 3'h0 && !analog_hold
                                  |-> target_freq == $past(src_freq))
    else $error("step zero does not follow the frequency command");
  chk_term_stop: assert property (s_r.rsrc == rcs_pkg::RSRC_TERM_FR && fx == rx
                                  |=> !run_enable)
    else $error("run continues with both terminal inputs equal");
  chk_inhibit_dir: assert property (run_enable |-> $past(s_r.inh) !=
                                    (dir_reverse ? rcs_pkg::INH_REV : rcs_pkg::INH_FWD))
    else $error("run in an inhibited direction");
  // A fresh start from standstill may pick either direction; only a running flip is guarded
  chk_reverse_stop: assert property (run_enable && $changed(dir_reverse) &&
                                     $past(s_r.state) != rcs_pkg::ST_STOP
                                     |-> $past(s_r.state) == rcs_pkg::ST_REVERSE &&
                                         $past(ramp_at_zero))
    else $error("direction flipped without stopping first");
  chk_latch_fault: assert property ($past(fault_active) |-> !s_r.kp_run && !s_r.ser_run)
    else $error("keypad or serial run survives a fault");
  chk_serial_gate: assert property ($changed(s_r.ser_run) |-> $past(fault_active) ||
                                    $past(s_r.rsrc) != rcs_pkg::RSRC_SERIAL ||
                                    $past(ser_cmd_valid && stn_ok))
    else $error("serial run changed without a matching command");
  chk_keypad_dir: assert property (run_enable && $past(s_r.state == rcs_pkg::ST_STOP &&
                                   s_r.rsrc == rcs_pkg::RSRC_KEYPAD && s_r.fsrc != 4'h2)
                                   |-> dir_reverse == $past(s_r.kdir))
    else $error("keypad start ignores keypad direction");
endmodule

/* tb/rcs_field_model.sv */
// Terminal strip and keypad model facing the drive
module rcs_field_model (
  // Clock
  input  wire logic       sys_clk,
  // Pins toward the drive
  output logic      [7:0] prog_in,
  output logic            key_run,
  output logic            key_stop,
  output logic            remote_present,
  output logic            bipolar_negative
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle terminals, only the body keypad fitted
  initial begin
    {prog_in, key_run, key_stop, remote_present, bipolar_negative} = '0;
  end
  // Levels change just after an edge, like a contact closing
  task automatic put(logic [7:0] v, logic neg);
    @(posedge sys_clk);
    prog_in <= v;
    bipolar_negative <= neg;
  endtask
  // Key held three cycles so the synchroniser sees one clean press
  task automatic press(logic stop);
    @(posedge sys_clk);
    key_run <= !stop;
    key_stop <= stop;
    repeat (3) @(posedge sys_clk);
    {key_run, key_stop} <= 2'b00;
  endtask
endmodule

/* tb/rcs_run_select_test.sv */
// Self-checking bench for the run command and step select block
module rcs_run_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rstn, reg_wr, reg_rd, ramp_at_zero, k_run, k_stop, rem, neg;
  logic [7:0]  reg_addr, prog_in, stn;
  logic [31:0] reg_wdata, reg_rdata, d, p;
  logic [15:0] src_freq, target_freq;
  logic [2:0]  step_index, rate;
  logic        flt, scv, scr, scrv, dec, hold;
  logic [7:0]  scs;
  logic        run_enable, dir_reverse;
  int          error_cnt, checked, src, f, rq, rv;
  int          preset[8] = '{0, 1000, 2000, 3000, 3000, 2500, 2000, 1500};
  rcs_run_select rcs_run_select_inst (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .prog_in(prog_in), .key_run_body(k_run), .key_stop_body(k_stop),
    .key_run_remote(k_run & rem), .key_stop_remote(k_stop & rem), .remote_present(rem),
    .bipolar_negative(neg), .fault_active(flt), .ramp_at_zero(ramp_at_zero),
    .src_freq(src_freq), .ser_cmd_valid(scv), .ser_cmd_station(scs), .ser_cmd_run(scr),
    .ser_cmd_reverse(scrv), .run_enable(run_enable), .decel_stop(dec), .dir_reverse(dir_reverse),
    .target_freq(target_freq), .step_index(step_index), .analog_hold(hold), .serial_protocol(),
    .station_number(stn), .serial_rate_code(rate));
  rcs_field_model fm (.sys_clk(sys_clk), .prog_in(prog_in), .key_run(k_run),
    .key_stop(k_stop), .remote_present(rem), .bipolar_negative(neg));
  // Crude ramp: at zero one cycle after run drops, enough to release a decel
  always @(posedge sys_clk) ramp_at_zero <= !run_enable;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (exp !== got) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask
  // Serial framer: one command pulse, fields held beside it
  task automatic ser(logic [7:0] s, logic r, logic v);
    {scs, scr, scrv, scv} <= {s, r, v, 1'b1};
    @(posedge sys_clk);
    scv <= 1'b0;
  endtask
  // Fault held a few cycles, then cleared
  task automatic fault(int cyc);
    flt <= 1'b1;
    repeat (cyc) @(posedge sys_clk);
    flt <= 1'b0;
  endtask
  // Model: inhibit vetoes the final direction, step only counts while running
  task automatic expect_run(int q, int r, int inh, int stp);
    int go;
    go = q && !(inh == 1 && !r) && !(inh == 2 && r);
    repeat (8) @(posedge sys_clk);
    #1;
    chk("run_enable", go, run_enable);
    chk("decel_stop", 0, dec);
    if (go) begin
      chk("dir_reverse", r, dir_reverse);
      chk("step_index", stp, step_index);
      chk("target_freq", stp ? preset[stp] : src, target_freq);
    end
    @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #400us;
    error_cnt++;
    close_out();
  end
  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, src_freq, flt, scv, scr, scrv, scs} = '0;
    void'($urandom(32'h0d1732e0));
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("station_number", 32'h1, stn);
    chk("serial_rate_code", 32'h3, rate);
    rd(8'h00);
    chk("ctrl", 32'h10, d);
    rd(8'h1C);
    chk("preset_speed_four", 32'hBB8, d);
    rd(8'h40);
    chk("unmapped", 32'h0, d);
    // Both terminal sources, inhibit values zero to two, random steps and polarity
    for (int rs = 1; rs <= 2; rs++) begin
      for (int inh = 0; inh <= 2; inh++) begin
        repeat (6) begin
          p = $urandom;
          f = p[8] ? 2 : 0;
          src = p[31:16];
          fm.put(8'h00, 1'b0);
          repeat (8) @(posedge sys_clk);
          wr(8'h00, f | rs << 4 | inh << 8);
          src_freq <= p[31:16];
          fm.put({p[7:5], 3'b000, p[1:0]}, p[9]);
          rq = rs == 1 ? p[0] ^ p[1] : p[0];
          rv = p[1] ^ (f == 2 && p[9]);
          expect_run(rq, rv, inh, rq ? p[7:5] : 0);
          if (f == 2) begin
            fm.put({p[7:5], 3'b000, p[1:0]}, !p[9]);
            expect_run(rq, !rv, inh, rq ? p[7:5] : 0);
          end
        end
      end
    end
    // Keypad source with reverse selected, then the stop key
    fm.put(8'h00, 1'b0);
    wr(8'h00, 32'h40);
    fm.press(1'b0);
    expect_run(1, 1, 0, 0);
    fm.press(1'b1);
    expect_run(0, 1, 0, 0);
    // Hold terminal on input three counts only for frequency sources two to seven
    wr(8'h04, 32'h03170100);
    fm.put(8'h04, 1'b0);
    wr(8'h00, 32'h35);
    repeat (4) @(posedge sys_clk);
    #1 chk("analog_hold", 1, hold);
    @(posedge sys_clk);
    wr(8'h00, 32'h30);
    repeat (3) @(posedge sys_clk);
    #1 chk("analog_hold", 0, hold);
    @(posedge sys_clk);
    // Serial source: own station runs, a foreign station is ignored
    p = $urandom;
    ser(8'h01, 1'b1, p[2]);
    expect_run(1, p[2], 0, 0);
    ser(8'h02, 1'b0, 1'b0);
    expect_run(1, p[2], 0, 0);
    ser(8'h01, 1'b0, 1'b0);
    expect_run(0, 0, 0, 0);
    // Fault clear restarts a held terminal run only with its autostart set
    wr(8'h00, 32'h810);
    fm.put(8'h01, 1'b0);
    expect_run(1, 0, 0, 0);
    fault(3);
    expect_run(1, 0, 0, 0);
    wr(8'h00, 32'h10);
    fault(3);
    expect_run(0, 0, 0, 0);
    close_out();
  end
endmodule
